// ---- common/wsc_regs.svh ----
// Register offsets, field positions, reset values and lookup constants
`ifndef WSC_REGS_SVH
`define WSC_REGS_SVH

`define WSC_OFF_SOURCE_CTRL 8'h03
`define WSC_OFF_LOOKUP_INDEX 8'h08
`define WSC_OFF_WIPER 8'h09
`define WSC_OFF_OVERRIDE_CTRL 8'h0a
`define WSC_OFF_TEMPERATURE 8'h0c
`define WSC_OFF_SUPPLY 8'h0e

`define WSC_BIT_AUTO_COMP 0
`define WSC_BIT_SUM_SELECT 1
`define WSC_BIT_INDEX_OVERRIDE 1
`define WSC_BIT_WIPER_OVERRIDE 2

`define WSC_RST_SOURCE_CTRL 8'h03
`define WSC_RST_OVERRIDE_CTRL 8'h00
`define WSC_RST_LOOKUP_INDEX 8'h00
`define WSC_RST_WIPER 8'h00
`define WSC_RST_RESULT 8'h00

`define WSC_SOURCE_CTRL_MASK 8'h03
`define WSC_OVERRIDE_CTRL_MASK 8'h07

`define WSC_TABLE_SLOTS 72
`define WSC_TEMP_OFFSET 40
`define WSC_WIPER_MAX 7'h7f

`endif

// ---- common/wsc_pkg.sv ----
// Types shared by the wiper source control block
package wsc_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } wsc_reg_req_t;

  typedef struct packed {
    logic frame_done;
    logic [7:0] temp;
    logic [7:0] supply;
  } wsc_conv_t;

  typedef enum logic [0:0] {
    WSC_RESTORE = 1'b0,
    WSC_RUN = 1'b1
  } wsc_phase_t;

endpackage

// ---- logic/wsc_regs_top.sv ----
// Wiper source control, override control and converter result registers
//
// How it works
// RQ1 - Source control at 03h, two bits, default 03
// RQ2 - Sum select matters only with auto compensation
// RQ3 - Sum select 0 loads lookup value directly
// RQ4 - Sum select 1 loads initial plus lookup
// RQ5 - Auto off: initial value drives the wiper
// RQ6 - Auto off: converter results stop updating
// RQ7 - Auto on: indexed table slot sets wiper
// RQ8 - Reset restores source control from nonvolatile copy
// RQ9 - Lookup index at 08h, zero until frame
// RQ10 - Index writable only with index override set
// RQ11 - Wiper at 09h, writable only when overridden
// RQ12 - Wiper refreshed each cycle in auto mode
// RQ13 - Master always writes zero to override bit 0
// RQ14 - Wiper override makes wiper bus-loaded only; ignored while auto is off, where initial writes still load it
// RQ15 - Index override stops automatic index updates
// RQ16 - Temperature at 0Ch, per frame, auto only
// RQ17 - Shadow select keeps writes out of nonvolatile
// RQ18 - Table entries signed in sum, else unsigned
// RQ19 - Sum clamped to 0..127, never wraps
// RQ20 - Refused override writes ignored but acknowledged
`timescale 1ns/10ps
`include "wsc_regs.svh"

module wsc_regs_top #(
  parameter int SLOTS = `WSC_TABLE_SLOTS,
  parameter int TEMP_OFFSET = `WSC_TEMP_OFFSET
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port from the serial interface engine
  input wire wsc_pkg::wsc_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  // Converter results, one frame_done pulse per frame
  input wire wsc_pkg::wsc_conv_t conv,
  // Lookup table slot addressed by table_index
  output logic [7:0] table_index,
  input wire logic [7:0] table_entry,
  // Initial value store and its wiper write-through
  input wire logic [7:0] initial_value,
  input wire logic initial_write,
  input wire logic [7:0] initial_wdata,
  // Shadow select and nonvolatile copy of source control
  input wire logic shadow_only,
  input wire logic [7:0] nv_recall,
  output logic nv_store,
  output logic [7:0] nv_data,
  // Wiper tap
  output logic [6:0] wiper
);

  wsc_pkg::wsc_phase_t phase_q;
  logic [7:0] src_ctrl_q;
  logic [7:0] ovr_ctrl_q;
  logic [7:0] index_q;
  logic [6:0] wiper_q;
  logic [7:0] temp_q;
  logic [7:0] supply_q;
  logic [7:0] rdata_q;
  logic nv_store_q;
  logic [7:0] nv_data_q;

  logic auto_on;
  logic sum_sel;
  logic wiper_ovr;
  logic index_ovr;
  logic run;
  logic frame_upd;
  logic [7:0] index_calc;
  logic [6:0] lookup_wiper;
  logic signed [8:0] sum_raw;
  logic [6:0] sum_sat;

  assign auto_on = src_ctrl_q[`WSC_BIT_AUTO_COMP];
  assign sum_sel = src_ctrl_q[`WSC_BIT_SUM_SELECT];
  assign wiper_ovr = ovr_ctrl_q[`WSC_BIT_WIPER_OVERRIDE];
  assign index_ovr = ovr_ctrl_q[`WSC_BIT_INDEX_OVERRIDE];
  assign run = (phase_q == wsc_pkg::WSC_RUN);
  assign frame_upd = run && auto_on && conv.frame_done; // RQ6

  function automatic logic wr_at(input logic [7:0] off);
    wr_at = reg_req.wr && (reg_req.addr == off);
  endfunction

  // Restore phase lets reset stay constant-only; strap-like values caught after release
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_q <= wsc_pkg::WSC_RESTORE;
    end else begin
      phase_q <= wsc_pkg::WSC_RUN;
    end
  end

  // Source control register
  always_ff @(posedge clk) begin
    if (rst) begin
      src_ctrl_q <= `WSC_RST_SOURCE_CTRL; // RQ1
    end else if (!run) begin
      src_ctrl_q <= nv_recall & `WSC_SOURCE_CTRL_MASK; // RQ8
    end else if (wr_at(`WSC_OFF_SOURCE_CTRL)) begin
      src_ctrl_q <= reg_req.wdata & `WSC_SOURCE_CTRL_MASK; // RQ1
    end
  end

  // Nonvolatile copy updated only when shadow select is clear
  always_ff @(posedge clk) begin
    if (rst) begin
      nv_store_q <= 1'b0;
      nv_data_q <= `WSC_RST_SOURCE_CTRL;
    end else begin
      nv_store_q <= run && wr_at(`WSC_OFF_SOURCE_CTRL) && !shadow_only; // RQ17 RQ8
      if (run && wr_at(`WSC_OFF_SOURCE_CTRL)) begin
        nv_data_q <= reg_req.wdata & `WSC_SOURCE_CTRL_MASK;
      end
    end
  end

  // Override control; bit 0 stored as written, the master keeps it zero
  always_ff @(posedge clk) begin
    if (rst) begin
      ovr_ctrl_q <= `WSC_RST_OVERRIDE_CTRL; // RQ13
    end else if (run && wr_at(`WSC_OFF_OVERRIDE_CTRL)) begin
      ovr_ctrl_q <= reg_req.wdata & `WSC_OVERRIDE_CTRL_MASK;
    end
  end

  // Temperature to slot: two degrees per slot, clamped to the table
  always_comb begin
    logic signed [9:0] shifted;
    shifted = $signed({{2{conv.temp[7]}}, conv.temp}) + 10'(TEMP_OFFSET);
    if (shifted < 0) begin
      index_calc = 8'h00;
    end else if ((shifted >>> 1) > 10'(SLOTS - 1)) begin
      index_calc = 8'(SLOTS - 1);
    end else begin
      index_calc = shifted[8:1];
    end
  end

  // Lookup index
  always_ff @(posedge clk) begin
    if (rst) begin
      index_q <= `WSC_RST_LOOKUP_INDEX; // RQ9
    end else if (run && index_ovr && wr_at(`WSC_OFF_LOOKUP_INDEX)) begin
      index_q <= reg_req.wdata; // RQ10
    end else if (frame_upd && !index_ovr) begin
      index_q <= index_calc; // RQ15 RQ7
    end
  end

  // Unsigned entry above the wiper range saturates rather than wrapping
  assign lookup_wiper = table_entry[7] ? `WSC_WIPER_MAX : table_entry[6:0]; // RQ18
  assign sum_raw = $signed({2'b00, initial_value[6:0]})
                   + $signed({{2{table_entry[6]}}, table_entry[6:0]}); // RQ18 RQ4

  always_comb begin
    if (sum_raw < 0) begin
      sum_sat = 7'h00; // RQ19
    end else if (sum_raw > $signed({2'b00, `WSC_WIPER_MAX})) begin
      sum_sat = `WSC_WIPER_MAX; // RQ19
    end else begin
      sum_sat = sum_raw[6:0];
    end
  end

  // Wiper source mux
  always_ff @(posedge clk) begin
    if (rst) begin
      wiper_q <= 7'(`WSC_RST_WIPER);
    end else if (!run) begin
      wiper_q <= initial_value[6:0]; // RQ5
    end else if (!auto_on) begin
      if (initial_write) begin
        wiper_q <= initial_wdata[6:0]; // RQ5 RQ12
      end
    end else if (wiper_ovr) begin
      if (wr_at(`WSC_OFF_WIPER)) begin
        wiper_q <= reg_req.wdata[6:0]; // RQ11 RQ14 RQ20
      end
    end else if (sum_sel) begin
      wiper_q <= sum_sat; // RQ4 RQ2 RQ12
    end else begin
      wiper_q <= lookup_wiper; // RQ3 RQ7 RQ12
    end
  end

  // Converter results frozen while auto compensation is off
  always_ff @(posedge clk) begin
    if (rst) begin
      temp_q <= `WSC_RST_RESULT;
      supply_q <= `WSC_RST_RESULT;
    end else if (frame_upd) begin
      temp_q <= conv.temp; // RQ16 RQ6
      supply_q <= conv.supply; // RQ6
    end
  end

  // Read data, one cycle after the read strobe; unmapped reads give zero
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (reg_req.rd) begin
      unique case (reg_req.addr)
        `WSC_OFF_SOURCE_CTRL: rdata_q <= src_ctrl_q;
        `WSC_OFF_LOOKUP_INDEX: rdata_q <= index_q; // RQ9
        `WSC_OFF_WIPER: rdata_q <= {1'b0, wiper_q}; // RQ11
        `WSC_OFF_OVERRIDE_CTRL: rdata_q <= ovr_ctrl_q;
        `WSC_OFF_TEMPERATURE: rdata_q <= temp_q; // RQ16
        `WSC_OFF_SUPPLY: rdata_q <= supply_q; // RQ6
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  assign reg_rdata = rdata_q;
  assign table_index = index_q;
  assign nv_store = nv_store_q;
  assign nv_data = nv_data_q;
  assign wiper = wiper_q;

  // All checks run on the system clock and pause in reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_ctrl_restore: assert property ( // RQ8
    !run |=> src_ctrl_q == ($past(nv_recall) & 8'h03))
    else $error("source control not restored from nonvolatile copy");

  a_index_reset: assert property ( // RQ9
    run && !$past(run) && !conv.frame_done && !reg_req.wr |=> index_q == 8'h00)
    else $error("lookup index not zero before first frame");

  a_index_lock: assert property ( // RQ10
    run && wr_at(8'h08) && !index_ovr && !conv.frame_done |=> $stable(index_q))
    else $error("lookup index written without override");

  a_index_manual: assert property ( // RQ15
    run && index_ovr && !wr_at(8'h08) |=> $stable(index_q))
    else $error("lookup index moved under override");

  a_wiper_manual: assert property ( // RQ14
    run && auto_on && wiper_ovr && !wr_at(8'h09) |=> $stable(wiper_q))
    else $error("wiper changed without bus write in manual mode");

  a_wiper_direct: assert property ( // RQ3
    run && auto_on && !wiper_ovr && !sum_sel && !table_entry[7]
    |=> {1'b0, wiper_q} == $past(table_entry))
    else $error("wiper not loaded directly from table entry");

  a_wiper_sum: assert property ( // RQ4
    run && auto_on && !wiper_ovr && sum_sel && !initial_value[6] && !table_entry[6]
    && !table_entry[5] |=> {1'b0, wiper_q}
    == ($past(initial_value) & 8'h7f) + ($past(table_entry) & 8'h7f))
    else $error("wiper not loaded with initial plus table entry");

  a_wiper_hold: assert property ( // RQ12
    run && !auto_on && !initial_write ##1 run |-> $stable(wiper_q))
    else $error("wiper moved while auto compensation is off");

  a_temp_freeze: assert property ( // RQ16
    !auto_on |=> $stable(temp_q) && $stable(supply_q))
    else $error("converter result updated with auto compensation off");

  a_temp_frame: assert property ( // RQ6
    run && auto_on && conv.frame_done |=> temp_q == $past(conv.temp))
    else $error("temperature not captured at frame end");

  a_nv_shadow: assert property ( // RQ17
    run && wr_at(8'h03) |=> nv_store_q == !$past(shadow_only))
    else $error("nonvolatile store does not follow shadow select");

  // Register writes land one cycle after the strobe
  a_ctrl_write: assert property ( // RQ1
    run && wr_at(8'h03) |=> src_ctrl_q == ($past(reg_req.wdata) & 8'h03))
    else $error("source control write not taken");

  a_ovr_write: assert property ( // RQ14
    run && wr_at(8'h0a) |=> ovr_ctrl_q == ($past(reg_req.wdata) & 8'h07))
    else $error("override control write not taken");

  a_index_write: assert property ( // RQ10
    run && index_ovr && wr_at(8'h08) |=> index_q == $past(reg_req.wdata))
    else $error("lookup index write refused under override");

  a_wiper_write: assert property ( // RQ11
    run && auto_on && wiper_ovr && wr_at(8'h09)
    |=> {1'b0, wiper_q} == ($past(reg_req.wdata) & 8'h7f))
    else $error("wiper write refused under override");

  // Automatic index: zero degrees sits half the offset up the table
  a_index_auto: assert property ( // RQ15
    run && auto_on && !index_ovr && conv.frame_done && conv.temp == 8'h00
    |=> index_q == 8'(TEMP_OFFSET / 2))
    else $error("lookup index not recomputed at frame end");

  a_supply_frame: assert property ( // RQ6
    run && auto_on && conv.frame_done |=> supply_q == $past(conv.supply))
    else $error("supply result not captured at frame end");

  // Clamp corners checked without the adder
  a_sum_low: assert property ( // RQ19
    run && auto_on && !wiper_ovr && sum_sel && table_entry[6] && initial_value[6:0] == 7'h00
    |=> wiper_q == 7'h00)
    else $error("negative sum not clamped to zero");

  a_sum_high: assert property ( // RQ19
    run && auto_on && !wiper_ovr && sum_sel && !table_entry[6] && initial_value[6:0] == 7'h7f
    |=> wiper_q == 7'h7f)
    else $error("large sum not clamped to full scale");

  a_lookup_sat: assert property ( // RQ18
    run && auto_on && !wiper_ovr && !sum_sel && table_entry[7] |=> wiper_q == 7'h7f)
    else $error("unsigned entry above range not saturated");

  a_restore_wiper: assert property ( // RQ5
    !run |=> {1'b0, wiper_q} == ($past(initial_value) & 8'h7f))
    else $error("wiper not loaded from initial value after reset");

  a_nv_quiet: assert property ( // RQ17
    !(run && wr_at(8'h03)) |=> !nv_store_q)
    else $error("nonvolatile store without source control write");

  // Read data shows the register as it stood at the strobe
  a_read_index: assert property ( // RQ9
    reg_req.rd && reg_req.addr == 8'h08 |=> reg_rdata == $past(index_q))
    else $error("lookup index read wrong");

  a_read_wiper: assert property ( // RQ11
    reg_req.rd && reg_req.addr == 8'h09 |=> reg_rdata == {1'b0, $past(wiper_q)})
    else $error("wiper read wrong");

  a_read_temp: assert property ( // RQ16
    reg_req.rd && reg_req.addr == 8'h0c |=> reg_rdata == $past(temp_q))
    else $error("temperature read wrong");

  // Main scenarios
  c_frame_update: cover property (run && auto_on && conv.frame_done ##1 temp_q != 8'h00);
  c_auto_off_load: cover property (run && !auto_on && initial_write);
  c_manual_wiper: cover property (run && auto_on && wiper_ovr && wr_at(8'h09));
  c_sum_clamp: cover property (run && auto_on && sum_sel && sum_raw < 0);
  c_index_manual: cover property (run && index_ovr && wr_at(8'h08));

endmodule // wsc_regs_top

// ---- bench/wsc_far_model.sv ----
// Far side model: lookup table store and nonvolatile source control copy
`timescale 1ns/10ps
module wsc_far_model (
  // Clock
  input wire logic clk,
  // Table port
  input wire logic [7:0] idx,
  output logic [7:0] entry,
  // Nonvolatile copy
  input wire logic store,
  input wire logic [7:0] data,
  output logic [7:0] recall
);
  logic [7:0] tbl [0:71];
  // Out of range slot gives a moving pattern, never a stale entry
  assign entry = (idx < 8'h48) ? tbl[idx] : ~idx;
  logic [7:0] recall_q = 8'h03;
  assign recall = recall_q;
  always @(posedge clk) begin
    if (store) begin
      recall_q <= data;
    end
  end
endmodule // wsc_far_model

// ---- bench/test_wsc_regs_top.sv ----
// Self-checking bench for the wiper source control registers
`timescale 1ns/10ps
module test_wsc_regs_top;
  logic clk, rst, iw, sh, s;
  logic [7:0] rdata, tidx, tent, iv, iwd, nvr, nvd, d, t, k;
  logic nvs;
  logic [6:0] wiper;
  wsc_pkg::wsc_reg_req_t req;
  wsc_pkg::wsc_conv_t conv;
  int n_errors = 0;
  int checks = 0;
  wsc_regs_top uut (.clk(clk), .rst(rst), .reg_req(req), .reg_rdata(rdata), .conv(conv),
    .table_index(tidx), .table_entry(tent), .initial_value(iv), .initial_write(iw),
    .initial_wdata(iwd), .shadow_only(sh), .nv_recall(nvr), .nv_store(nvs),
    .nv_data(nvd), .wiper(wiper));
  wsc_far_model fm (.clk(clk), .idx(tidx), .entry(tent), .store(nvs), .data(nvd),
    .recall(nvr));
  always #2 clk = ~clk;
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] v);
    @(negedge clk) req = '{1'b1, 1'b0, a, v};
    @(negedge clk) req.wr = 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    @(negedge clk) req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk) req.rd = 1'b0;
    d = rdata;
  endtask
  task automatic frame(logic [7:0] v);
    @(negedge clk) conv = '{1'b1, v, ~v};
    @(negedge clk) conv = '{1'b0, ~v, v};
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  // Signed entry plus initial value with sum select, else unsigned entry alone; clamped so the tap never wraps
  function automatic logic [7:0] ew(logic sm, logic [7:0] i, logic [7:0] e);
    int v;
    if (!sm) return e[7] ? 8'h7f : {1'b0, e[6:0]};
    v = int'(i[6:0]) + int'($signed(e[6:0]));
    if (v < 0) v = 0;
    if (v > 127) v = 127;
    return v[7:0];
  endfunction
  function automatic logic [7:0] ei(logic [7:0] v);
    int x;
    x = (int'($signed(v)) + 40) / 2;
    if (x < 0) x = 0;
    if (x > 71) x = 71;
    return x[7:0];
  endfunction
  initial begin
    #200000;
    n_errors++;
    complete_run();
  end
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    req = '0;
    conv = '0;
    iv = 8'h25;
    iw = 1'b0;
    iwd = 8'h00;
    sh = 1'b0;
    s = 1'b1;
    void'($urandom(32'hfd17));
    for (int i = 0; i < 72; i++) begin
      fm.tbl[i] = 8'($urandom);
    end
    cyc(3);
    rst = 1'b0;
    cyc(1);
    rd(8'h03);
    chk(d, 8'h03);
    rd(8'h0a);
    chk(d, 8'h00);
    rd(8'h08);
    chk(d, 8'h00);
    chk(tidx, 8'h00);
    chk({1'b0, wiper}, ew(1'b1, iv, fm.tbl[0]));
    for (int i = 0; i < 40; i++) begin
      s = i[0];
      wr(8'h03, {6'h00, s, 1'b1});
      t = (i < 2) ? {i[0], 7'h00} : 8'($urandom);
      iv = (i < 4) ? {1'b0, {7{i[1]}}} : 8'($urandom);
      frame(t);
      rd(8'h0c);
      chk(d, t);
      rd(8'h0e);
      chk(d, ~t);
      rd(8'h08);
      chk(d, ei(t));
      chk(tidx, ei(t));
      cyc(1);
      chk({1'b0, wiper}, ew(s, iv, fm.tbl[ei(t)]));
    end
    k = 8'h05;
    wr(8'h0a, 8'h02);
    wr(8'h08, k);
    frame(8'h10);
    rd(8'h08);
    chk(d, k);
    chk({1'b0, wiper}, ew(s, iv, fm.tbl[k]));
    wr(8'h0a, 8'h00);
    wr(8'h08, 8'h09);
    rd(8'h08);
    chk(d, k);
    wr(8'h0a, 8'h04);
    wr(8'h09, 8'h5a);
    iv = 8'h11;
    cyc(3);
    rd(8'h09);
    chk(d, 8'h5a);
    wr(8'h0a, 8'h00);
    wr(8'h09, 8'h3c);
    cyc(2);
    chk({1'b0, wiper}, ew(s, iv, fm.tbl[k]));
    wr(8'h03, 8'h00);
    chk({7'h00, nvs}, 8'h01);
    chk(nvd, 8'h00);
    frame(8'h33);
    rd(8'h0c);
    chk(d, 8'h10);
    rd(8'h0e);
    chk(d, 8'hef);
    @(negedge clk);
    iw = 1'b1;
    iwd = 8'hc4;
    @(negedge clk);
    iw = 1'b0;
    cyc(1);
    chk({1'b0, wiper}, 8'h44);
    wr(8'h03, 8'h02);
    cyc(3);
    chk({1'b0, wiper}, 8'h44);
    wr(8'h0a, 8'h04);
    wr(8'h09, 8'h7e);
    chk({1'b0, wiper}, 8'h44);
    sh = 1'b1;
    wr(8'h03, 8'hfd);
    chk({7'h00, nvs}, 8'h00);
    rd(8'h03);
    chk(d, 8'h01);
    iv = 8'h9b;
    rst = 1'b1;
    cyc(3);
    rst = 1'b0;
    cyc(2);
    rd(8'h03);
    chk(d, 8'h02);
    chk(tidx, 8'h00);
    chk({1'b0, wiper}, 8'h1b);
    complete_run();
  end
endmodule // test_wsc_regs_top
